/* File: pcg_pkg.sv */
package pcg_pkg;

    // ==================================================================
    // Register offsets (byte addresses within the block).
    // ==================================================================
    localparam logic [11:0] PCG_OFF_RUN0    = 12'h100;
    localparam logic [11:0] PCG_OFF_RUN1    = 12'h104;
    localparam logic [11:0] PCG_OFF_SLP0    = 12'h110;
    localparam logic [11:0] PCG_OFF_SLP1    = 12'h114;
    localparam logic [11:0] PCG_OFF_DSL0    = 12'h120;
    localparam logic [11:0] PCG_OFF_DSL1    = 12'h124;
    localparam logic [11:0] PCG_OFF_CFG     = 12'h060;
    localparam logic [11:0] PCG_OFF_STATUS  = 12'h130;
    localparam logic [11:0] PCG_OFF_FAULT   = 12'h134;

    // ==================================================================
    // Writable bit masks; every other bit is reserved and reads zero.
    // ==================================================================
    localparam logic [31:0] PCG_MASK_REG0   = 32'h0010_0048;
    localparam logic [31:0] PCG_MASK_REG1   = 32'h0707_1133;
    localparam logic [31:0] PCG_MASK_CFG    = 32'h0000_0001;

    // ==================================================================
    // Reset values.
    // ==================================================================
    localparam logic [31:0] PCG_RST_RUN0    = 32'h0000_0040;
    localparam logic [31:0] PCG_RST_SLP0    = 32'h0000_0040;
    localparam logic [31:0] PCG_RST_DSL0    = 32'h0000_0040;
    localparam logic [31:0] PCG_RST_REG1    = 32'h0000_0000;
    localparam logic [31:0] PCG_RST_CFG     = 32'h0000_0000;

    // ==================================================================
    // Field positions in gating registers 0 and 1, and in the config.
    // ==================================================================
    localparam int PCG_BIT_PWM   = 20;
    localparam int PCG_BIT_HIBERNATE = 6;
    localparam int PCG_BIT_WATCHDOG  = 3;
    localparam int PCG_BIT_CMP0  = 24;
    localparam int PCG_BIT_TMR0  = 16;
    localparam int PCG_BIT_TWI0  = 12;
    localparam int PCG_BIT_QUAD0 = 8;
    localparam int PCG_BIT_SYNC0 = 4;
    localparam int PCG_BIT_SER0  = 0;
    localparam int PCG_BIT_AUTOGATE = 0;

    // ==================================================================
    // Number of gated unit slots in the enable vector.
    // ==================================================================
    localparam int PCG_NUNITS    = 16;

    // Power modes presented by the core.
    typedef enum logic [1:0] {
        PCG_MODE_RUN,
        PCG_MODE_SLEEP,
        PCG_MODE_DEEP
    } pcg_mode_t;

endpackage

/* File: pcg_gate_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries the selected gating words and per-unit enables between top and the enable map.
interface pcg_gate_if;
    logic [31:0] sel0;
    logic [31:0] sel1;
    logic [15:0] en;
    modport src (output sel0, output sel1, input en);
    modport dst (input sel0, input sel1, output en);
endinterface
`default_nettype wire

/* File: pcg_enmap.sv */
`timescale 1ns/1ps
`default_nettype none
// Maps the two selected gating words onto the per-unit enable vector.
module pcg_enmap
    import pcg_pkg::*;
(
    pcg_gate_if.dst g    // Selected gating words in, enables out.
);
    // ==================================================================
    // Unit enable mapping.
    // ==================================================================
    // RULE_01 - bit drives enable.
    assign g.en = {g.sel0[PCG_BIT_PWM], g.sel0[PCG_BIT_HIBERNATE], g.sel0[PCG_BIT_WATCHDOG],
                   g.sel1[PCG_BIT_CMP0+2], g.sel1[PCG_BIT_CMP0+1], g.sel1[PCG_BIT_CMP0],
                   g.sel1[PCG_BIT_TMR0+2], g.sel1[PCG_BIT_TMR0+1], g.sel1[PCG_BIT_TMR0],
                   g.sel1[PCG_BIT_TWI0], g.sel1[PCG_BIT_QUAD0],
                   g.sel1[PCG_BIT_SYNC0+1], g.sel1[PCG_BIT_SYNC0],
                   g.sel1[PCG_BIT_SER0+1], g.sel1[PCG_BIT_SER0], 1'b0};
endmodule
`default_nettype wire

/* File: pcg_top.sv */
// Contract
// RULE_01 - Each gating bit enables one unit clock.
// RULE_02 - Access to gated unit returns bus fault.
// RULE_03 - Gating bits reset to zero unless noted.
// RULE_04 - Separate run, sleep, deep-sleep register sets.
// RULE_05 - Sleep sets apply only with auto-gating.
// RULE_06 - Deep-sleep register 0 at 0x120.
// RULE_07 - Bit 3 enables watchdog in sleep sets.
// RULE_08 - Reserved bits read zero, ignore writes.
// RULE_09 - Software preserves reserved bits on update.
// RULE_10 - Run register 1 at 0x104, resets zero.
// RULE_11 - Bits 26:24 enable comparators 2..0.
// RULE_12 - Bits 18:16 enable timers 2..0.
// RULE_13 - Bit 12 enables two-wire controller.
// RULE_14 - Bit 8 enables quadrature encoder.
// RULE_15 - Bits 5:4 sync serial, 1:0 serial.
// RULE_16 - Mode picks run, sleep or deep set.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pcg_top
    import pcg_pkg::*;
#(
    parameter int UNIT_ADDR_W = 4    // Width of the unit select field.
)
(
    input  wire logic        pclk,          // System clock, 50 MHz.
    input  wire logic        presetn,       // Asynchronous reset, active low.
    input  wire logic        psel,          // APB select.
    input  wire logic        penable,       // APB access phase.
    input  wire logic        pwrite,        // APB write when high.
    input  wire logic [11:0] paddr,         // APB byte address.
    input  wire logic [31:0] pwdata,        // APB write data.
    input  wire logic [3:0]  pstrb,         // APB byte strobes.
    output logic [31:0]      prdata,        // APB read data.
    output logic             pready,        // APB ready.
    output logic             pslverr,       // APB error on unmapped address.
    input  wire logic [1:0]  power_mode,    // Core mode: run, sleep, deep.
    input  wire logic        unit_access,   // Core is accessing a peripheral.
    input  wire logic [3:0]  unit_index,    // Index of the accessed unit.
    output logic             bus_fault,     // Access hit an unclocked unit.
    output logic [15:0]      unit_clk_en    // Per-unit clock enables.
);
    // ==================================================================
    // Elaboration checks.
    // ==================================================================
    if (UNIT_ADDR_W != 4) begin : g_bad_width
        $error("pcg_top supports only a four-bit unit index");
    end

    // ==================================================================
    // State.
    // ==================================================================
    typedef struct packed {
        logic [31:0] run0;
        logic [31:0] run1;
        logic [31:0] slp0;
        logic [31:0] slp1;
        logic [31:0] dsl0;
        logic [31:0] dsl1;
        logic [31:0] cfg;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        fault;
        logic        fault_seen;
        logic [3:0]  fault_unit;
        logic [15:0] clk_en;
    } pcg_state_t;

    pcg_state_t s_q;
    pcg_state_t s_d;

    pcg_gate_if gi ();
    pcg_mode_t  mode;
    logic [31:0] wmask;
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rd;

    assign mode = pcg_mode_t'(power_mode);

    // ==================================================================
    // Gate set selection.
    // ==================================================================
    // Sleep sets only steer the clocks once auto-gating is armed, so
    // software can program them ahead of time without side effects.
    // RULE_16 - mode selects set.
    always_comb begin
        gi.sel0 = s_q.run0;
        gi.sel1 = s_q.run1;
        // RULE_05 - auto-gating qualifies.
        if (s_q.cfg[PCG_BIT_AUTOGATE]) begin
            unique case (mode)
                PCG_MODE_RUN: begin
                    gi.sel0 = s_q.run0;
                    gi.sel1 = s_q.run1;
                end
                PCG_MODE_SLEEP: begin
                    gi.sel0 = s_q.slp0;
                    gi.sel1 = s_q.slp1;
                end
                PCG_MODE_DEEP: begin
                    gi.sel0 = s_q.dsl0;
                    gi.sel1 = s_q.dsl1;
                end
                default: begin
                    gi.sel0 = s_q.run0;
                    gi.sel1 = s_q.run1;
                end
            endcase
        end
    end

    pcg_enmap u_enmap (
        .g (gi)
    );

    // ==================================================================
    // APB decode and read mux.
    // ==================================================================
    // Strobes expand to a per-byte mask; narrow writes touch only their lanes.
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign acc   = psel && penable && !s_q.ready;
    // A write lands only on the edge at which the master sees ready high.
    assign wr    = psel && penable && s_q.ready && pwrite;

    // RULE_08 - reserved read zero.
    always_comb begin
        hit = 1'b1;
        rd  = 32'h0000_0000;
        unique case (paddr)
            PCG_OFF_RUN0:   rd = s_q.run0;
            PCG_OFF_RUN1:   rd = s_q.run1;
            PCG_OFF_SLP0:   rd = s_q.slp0;
            PCG_OFF_SLP1:   rd = s_q.slp1;
            PCG_OFF_DSL0:   rd = s_q.dsl0;
            PCG_OFF_DSL1:   rd = s_q.dsl1;
            PCG_OFF_CFG:    rd = s_q.cfg;
            PCG_OFF_STATUS: rd = {16'h0000, s_q.clk_en};
            PCG_OFF_FAULT:  rd = {26'h000_0000, s_q.fault_seen, s_q.fault, s_q.fault_unit};
            default:        hit = 1'b0;
        endcase
    end

    // ==================================================================
    // Next-state logic.
    // ==================================================================
    // One wait state: ready rises at the end of the first access cycle and the
    // transfer completes on the following edge. Writes are held back to
    // that completing edge, so a register never changes before the
    // master has seen the answer.
    always_comb begin
        s_d       = s_q;
        s_d.ready = acc;
        s_d.err   = acc && !hit;
        s_d.rdata = (acc && !pwrite) ? rd : 32'h0000_0000;
        if (wr && hit) begin
            unique case (paddr)
                // RULE_08 - mask reserved bits.
                PCG_OFF_RUN0:
                    s_d.run0 = (s_q.run0 & ~wmask) | (pwdata & wmask & PCG_MASK_REG0);
                // RULE_10 - run register 1.
                // RULE_11 - comparator enables.
                // RULE_12 - timer enables.
                // RULE_13 - two-wire enable.
                // RULE_14 - encoder enable.
                // RULE_15 - serial enables.
                PCG_OFF_RUN1:
                    s_d.run1 = (s_q.run1 & ~wmask) | (pwdata & wmask & PCG_MASK_REG1);
                // RULE_07 - watchdog bit writable.
                PCG_OFF_SLP0:
                    s_d.slp0 = (s_q.slp0 & ~wmask) | (pwdata & wmask & PCG_MASK_REG0);
                PCG_OFF_SLP1:
                    s_d.slp1 = (s_q.slp1 & ~wmask) | (pwdata & wmask & PCG_MASK_REG1);
                // RULE_06 - deep-sleep register 0.
                PCG_OFF_DSL0:
                    s_d.dsl0 = (s_q.dsl0 & ~wmask) | (pwdata & wmask & PCG_MASK_REG0);
                PCG_OFF_DSL1:
                    s_d.dsl1 = (s_q.dsl1 & ~wmask) | (pwdata & wmask & PCG_MASK_REG1);
                PCG_OFF_CFG:
                    s_d.cfg  = (s_q.cfg & ~wmask) | (pwdata & wmask & PCG_MASK_CFG);
                PCG_OFF_FAULT:
                    // Writing one to bit 5 clears the sticky flag; the recorded unit stays.
                    if (pwdata[5] && pstrb[0]) begin
                        s_d.fault_seen = 1'b0;
                    end
                default: ;
            endcase
        end
        // RULE_01 - enables registered out.
        s_d.clk_en = gi.en;
        // RULE_02 - fault on gated unit.
        s_d.fault = unit_access && !s_q.clk_en[unit_index];
        // A new fault wins over a clear in the same cycle.
        if (s_d.fault) begin
            s_d.fault_seen = 1'b1;
            s_d.fault_unit = unit_index;
        end
    end

    // ==================================================================
    // State register.
    // ==================================================================
    // RULE_03 - reset values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q            <= '0;
            s_q.run0       <= PCG_RST_RUN0;
            s_q.run1       <= PCG_RST_REG1;
            s_q.slp0       <= PCG_RST_SLP0;
            s_q.slp1       <= PCG_RST_REG1;
            s_q.dsl0       <= PCG_RST_DSL0;
            s_q.dsl1       <= PCG_RST_REG1;
            s_q.cfg        <= PCG_RST_CFG;
        end else begin
            // RULE_04 - three sets held.
            s_q <= s_d;
        end
    end

    // ==================================================================
    // Outputs.
    // ==================================================================
    assign prdata      = s_q.rdata;
    assign pready      = s_q.ready;
    assign pslverr     = s_q.err;
    assign bus_fault   = s_q.fault;
    assign unit_clk_en = s_q.clk_en;

endmodule
`default_nettype wire

/* File: pcg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Port checker for the clock gating block.
// ==================================================================
module pcg_checker
    import pcg_pkg::*;
#(
    parameter int UNIT_ADDR_W = 4    // Unit select width.
)
(
    input wire logic        pclk,        // Clock.
    input wire logic        presetn,     // Reset, active low.
    input wire logic        psel,        // APB select.
    input wire logic        penable,     // APB enable.
    input wire logic        pwrite,      // APB write.
    input wire logic [11:0] paddr,       // APB address.
    input wire logic [31:0] pwdata,      // APB write data.
    input wire logic [3:0]  pstrb,       // APB strobes.
    input wire logic [31:0] prdata,      // APB read data.
    input wire logic        pready,      // APB ready.
    input wire logic        pslverr,     // APB error.
    input wire logic [1:0]  power_mode,  // Core mode.
    input wire logic        unit_access, // Unit access.
    input wire logic [3:0]  unit_index,  // Unit index.
    input wire logic        bus_fault,   // Fault out.
    input wire logic [15:0] unit_clk_en  // Enables out.
);
    // Helpers keep $past on plain signals rather than selects.
    logic sel_en;
    logic wdat0;
    assign sel_en = unit_clk_en[unit_index];
    assign wdat0  = pwdata[0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A completed write to run register 1 while running.
    sequence run1_write;
        psel && penable && pready && pwrite && pstrb[0] && paddr == PCG_OFF_RUN1 &&
        power_mode == 2'b00;
    endsequence

    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready did not follow the access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without an access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    a_reserved_zero: assert property (
        pready && !pwrite && paddr == PCG_OFF_RUN1 |-> (prdata & ~PCG_MASK_REG1) == 32'h0)
        else $error("reserved bit read as one");
    a_fault_match: assert property (unit_access |=> bus_fault == !$past(sel_en))
        else $error("fault does not match enable");
    a_fault_idle: assert property (!unit_access |=> !bus_fault)
        else $error("fault without access");
    a_unit0_off: assert property (unit_clk_en[0] == 1'b0)
        else $error("unused unit enabled");
    a_run1_enable: assert property (
        run1_write ##1 (power_mode == 2'b00) |=> unit_clk_en[1] == $past(wdat0, 2))
        else $error("run enable did not follow write");
endmodule

bind pcg_top pcg_checker #(.UNIT_ADDR_W(UNIT_ADDR_W)) i_pcg_checker (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_mode(power_mode), .unit_access(unit_access), .unit_index(unit_index),
    .bus_fault(bus_fault), .unit_clk_en(unit_clk_en));
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, unit_access, pready, pslverr, bus_fault;
    logic        err, autog;
    logic [3:0]  strb, ln, lastf;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, d, wm;
    logic [3:0]  unit_index;
    logic [1:0]  power_mode;
    logic [15:0] unit_clk_en, e;
    logic [31:0] regs [6];
    logic [11:0] offs [6];
    int          bad_count, total_checks, k, r, m, u;

    pcg_top i_pcg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
        .unit_access(unit_access), .unit_index(unit_index), .bus_fault(bus_fault),
        .unit_clk_en(unit_clk_en));

    // ==================================================================
    // Helpers: random source, expected enables, compare, bus cycle.
    // ==================================================================
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Sleep and deep sets only count while automatic gating is on.
    function automatic logic [15:0] exp_en(input logic [1:0] mo);
        int s;
        logic [31:0] a, b;
        s = (autog && mo == 2'd1) ? 1 : ((autog && mo == 2'd2) ? 2 : 0);
        a = regs[2*s];
        b = regs[2*s+1];
        return {a[20], a[6], a[3], b[26:24], b[18:16], b[12], b[8], b[5:4], b[1:0], 1'b0};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The master waits for ready as long as it takes; only the watchdog ends a hang.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        strb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reload the model with the reset values and read every gating register back.
    task automatic check_reset();
        autog = 1'b0;
        regs = '{PCG_RST_RUN0, PCG_RST_REG1, PCG_RST_SLP0,
                 PCG_RST_REG1, PCG_RST_DSL0, PCG_RST_REG1};
        for (k = 0; k < 6; k++) begin
            apb(1'b0, offs[k], 32'h0, 4'hF);
            check(rd, regs[k]);
        end
        check({16'h0, unit_clk_en}, {16'h0, exp_en(2'd0)});
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // The run needs about 2000 cycles; this leaves ample margin.
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end

    // ==================================================================
    // Main sequence.
    // ==================================================================
    initial begin
        seed = 32'h0000002A;
        {presetn, psel, penable, pwrite, unit_access, autog} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        strb = 4'hF;
        lastf = 4'h0;
        unit_index = 4'h0;
        power_mode = 2'd0;
        offs = '{PCG_OFF_RUN0, PCG_OFF_RUN1, PCG_OFF_SLP0,
                 PCG_OFF_SLP1, PCG_OFF_DSL0, PCG_OFF_DSL1};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check_reset();
        // Six full-word random writes, one per register, first, then random registers and byte lanes.
        for (r = 0; r < 12; r++) begin
            d = rnd();
            k = (r < 6) ? r : int'(d[2:0]) % 6;
            ln = (r < 6) ? 4'hF : d[7:4];
            wm = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
            d = rnd();
            apb(1'b1, offs[k], d, ln);
            regs[k] = (regs[k] & ~wm) | (d & wm & (k[0] ? PCG_MASK_REG1 : PCG_MASK_REG0));
            apb(1'b0, offs[k], 32'h0, 4'hF);
            check(rd, regs[k]);
            autog = r[0];
            apb(1'b1, PCG_OFF_CFG, {31'h0, autog}, 4'hF);
            apb(1'b0, PCG_OFF_CFG, 32'h0, 4'hF);
            check(rd, {31'h0, autog});
            for (m = 3; m >= 0; m--) begin
                @(posedge pclk);
                power_mode <= m[1:0];
                repeat (2) @(posedge pclk);
                #1;
                e = exp_en(m[1:0]);
                check({16'h0, unit_clk_en}, {16'h0, e});
                for (u = 0; u < 16; u++) begin
                    @(posedge pclk);
                    unit_access <= 1'b1;
                    unit_index <= u[3:0];
                    @(posedge pclk);
                    unit_access <= 1'b0;
                    #1;
                    check({31'h0, bus_fault}, {31'h0, ~e[u]});
                    if (!e[u]) lastf = u[3:0];
                end
            end
        end
        // The sticky record names the last faulted unit; writing bit 5 clears its flag and keeps the unit.
        apb(1'b0, PCG_OFF_FAULT, 32'h0, 4'hF);
        check(rd, {26'h0, 1'b1, 1'b0, lastf});
        apb(1'b1, PCG_OFF_FAULT, 32'h20, 4'hF);
        apb(1'b0, PCG_OFF_FAULT, 32'h0, 4'hF);
        check(rd, {26'h0, 1'b0, 1'b0, lastf});
        apb(1'b0, PCG_OFF_STATUS, 32'h0, 4'hF);
        check(rd, {16'h0, exp_en(2'd0)});
        // Software update by read-modify-write, keeping the reserved bits.
        apb(1'b0, PCG_OFF_RUN1, 32'h0, 4'hF);
        d = (rd & ~PCG_MASK_REG1) | (rnd() & PCG_MASK_REG1);
        apb(1'b1, PCG_OFF_RUN1, d, 4'hF);
        apb(1'b0, PCG_OFF_RUN1, 32'h0, 4'hF);
        check(rd, d);
        apb(1'b0, 12'hFFC, 32'h0, 4'hF);
        check({31'h0, err}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        check_reset();
        apb(1'b0, PCG_OFF_RUN1, 32'h0, 4'hF);
        check(rd, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
